// File: src/ddreg_cfg.svh
`ifndef DDREG_CFG_SVH
`define DDREG_CFG_SVH
`define DDREG_OFS_LOW     8'h27
`define DDREG_OFS_DP      8'h28
`define DDREG_OFS_TIM     8'h29
`define DDREG_OFS_COL     8'h2a
`define DDREG_RST_LOW     8'h84
`define DDREG_RST_DP      8'h20
`define DDREG_RST_TIM     8'h00
`define DDREG_RST_COL     8'h00
`define DDREG_MASK_DP     8'hbf
`define DDREG_MASK_COL    8'hf0
`define DDREG_STEP_NS     50
`define DDREG_CLK_NS      10
`define DDREG_STEP_CYC    ((`DDREG_STEP_NS + `DDREG_CLK_NS - 1) / `DDREG_CLK_NS)
`endif

// File: src/ddreg_pkg.sv
package ddreg_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ddreg_req_t;
   typedef struct packed {
      logic       block_remote_load;
      logic       rsv6;
      logic       video_off;
      logic       dual_link;
      logic       alt_audio;
      logic       audio_off;
      logic       video_28bit;
      logic       surround;
   } ddreg_dp_t;
   typedef struct packed {
      logic       sync_timing;
      logic       hsync_invert;
      logic       vsync_invert;
      logic       data_enable_invert;
      logic       dither_stage_b_on;
      logic       dither_stage_a_on;
      logic       dither_stage_b_high_off;
      logic       dither_stage_a_high_off;
   } ddreg_tim_t;
   typedef struct packed {
      logic [1:0] page;
      logic       wb_on;
      logic       table_reload_on;
      logic [3:0] rsv;
   } ddreg_col_t;
   typedef enum logic [1:0] {
      DDREG_IDLE,
      DDREG_LOW,
      DDREG_SETUP
   } ddreg_phase_t;
   typedef struct packed {
      logic [7:0]   low;
      ddreg_dp_t    dp;
      ddreg_tim_t   tim;
      ddreg_col_t   col;
      logic [7:0]   rdata;
      logic         rvalid;
      ddreg_phase_t phase;
      logic [2:0]   sub;
      logic [7:0]   cnt;
      logic         scl_low;
      logic         scl_release;
      logic         lock;
      logic [1:0]   lnk_s;
      logic [1:0]   vid_s;
   } ddreg_state_t;
endpackage

// File: src/ddreg_top.sv
`timescale 1ns/1ps
`include "ddreg_cfg.svh"
module ddreg_top
   import ddreg_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire ddreg_req_t req,
   input  wire logic       fc_load,
   input  wire logic [7:0] fc_data,
   input  wire logic       ctl_low_start,
   input  wire logic       tgt_setup_start,
   input  wire logic       link_up_pin,
   input  wire logic       video_active_pin,
   output logic [7:0]      rdata,
   output logic            rvalid,
   output logic            scl_drive_low,
   output logic            scl_release,
   output logic            lock_out,
   output ddreg_dp_t       dp_cfg,
   output ddreg_tim_t      tim_cfg,
   output ddreg_col_t      col_cfg
);
   ddreg_state_t s_q;
   ddreg_state_t s_d;

   function automatic logic [7:0] rd_mux(input ddreg_state_t s,
                                         input logic [7:0] a);
      case (a)
         `DDREG_OFS_LOW: rd_mux = s.low;
         `DDREG_OFS_DP:  rd_mux = s.dp & `DDREG_MASK_DP;
         `DDREG_OFS_TIM: rd_mux = s.tim;
         `DDREG_OFS_COL: rd_mux = s.col & `DDREG_MASK_COL;
         default:        rd_mux = 8'h00;
      endcase
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.scl_release = 1'b0;
      s_d.lnk_s = {s_q.lnk_s[0], link_up_pin};
      s_d.vid_s = {s_q.vid_s[0], video_active_pin};
      // Remote load first, so a local write in the same cycle wins
      if (fc_load && !s_q.dp.block_remote_load) begin
         s_d.dp = fc_data & `DDREG_MASK_DP;
      end
      if (req.wr) begin
         case (req.addr)
            `DDREG_OFS_LOW: s_d.low = req.wdata;
            `DDREG_OFS_DP:  s_d.dp = req.wdata & `DDREG_MASK_DP;
            `DDREG_OFS_TIM: s_d.tim = req.wdata;
            `DDREG_OFS_COL: s_d.col = req.wdata & `DDREG_MASK_COL;
            default:        s_d.low = s_q.low;
         endcase
      end
      // Status after the local write, so the link report wins a same-cycle clash
      if (!s_q.dp.block_remote_load && s_q.lnk_s[1]) begin
         s_d.dp.video_off = !s_q.vid_s[1];
      end
      if (req.rd) begin
         s_d.rdata = rd_mux(s_q, req.addr);
         s_d.rvalid = 1'b1;
      end
      // Low count is sampled at start; later writes apply to the next phase
      case (s_q.phase)
         DDREG_IDLE: begin
            s_d.sub = 3'd0;
            s_d.cnt = s_q.low;
            if (ctl_low_start) begin
               s_d.phase = DDREG_LOW;
               s_d.scl_low = 1'b1;
            end else if (tgt_setup_start) begin
               s_d.phase = DDREG_SETUP;
               s_d.scl_low = 1'b1;
            end
         end
         DDREG_LOW, DDREG_SETUP: begin
            if (s_q.sub == 3'(`DDREG_STEP_CYC - 1)) begin
               s_d.sub = 3'd0;
               if (s_q.cnt <= 8'd1) begin
                  s_d.phase = DDREG_IDLE;
                  s_d.scl_low = 1'b0;
                  s_d.scl_release = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt - 8'd1;
               end
            end else begin
               s_d.sub = s_q.sub + 3'd1;
            end
         end
         default: begin
            s_d.phase = DDREG_IDLE;
            s_d.scl_low = 1'b0;
         end
      endcase
      s_d.lock = s_q.lnk_s[1] && !s_q.dp.video_off;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.low <= `DDREG_RST_LOW;
         s_q.dp <= `DDREG_RST_DP;
         s_q.tim <= `DDREG_RST_TIM;
         s_q.col <= `DDREG_RST_COL;
         s_q.phase <= DDREG_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   assign scl_drive_low = s_q.scl_low;
   assign scl_release = s_q.scl_release;
   assign lock_out = s_q.lock;
   assign dp_cfg = s_q.dp;
   assign tim_cfg = s_q.tim;
   assign col_cfg = s_q.col;

   chk_low_reset: assert property (@(posedge core_clk)
      $fell(rst) |-> s_q.low == 8'h84)
      else $error("low count reset wrong");
   chk_block_load: assert property (@(posedge core_clk) disable iff (rst)
      fc_load && s_q.dp.block_remote_load && !req.wr && !s_q.lnk_s[1]
      |=> $stable(s_q.dp))
      else $error("remote load not blocked");
   chk_lock_video: assert property (@(posedge core_clk) disable iff (rst)
      lock_out |-> $past(!s_q.dp.video_off))
      else $error("lock while video off");
   chk_rsv_zero: assert property (@(posedge core_clk) disable iff (rst)
      !s_q.dp.rsv6 && s_q.col.rsv == 4'h0)
      else $error("reserved bit set");
   chk_low_len: assert property (@(posedge core_clk) disable iff (rst)
      s_q.phase == DDREG_IDLE && (ctl_low_start || tgt_setup_start)
      && s_q.low == 8'd2
      |=> scl_drive_low [*8] ##1 scl_drive_low [*2] ##1 !scl_drive_low)
      else $error("low time length wrong");
   chk_setup_rel: assert property (@(posedge core_clk) disable iff (rst)
      scl_release |-> $past(scl_drive_low) && !scl_drive_low)
      else $error("release without setup");
   chk_tim_write: assert property (@(posedge core_clk) disable iff (rst)
      req.wr && req.addr == 8'h29 |=> tim_cfg == $past(req.wdata))
      else $error("timing write lost");
   chk_col_write: assert property (@(posedge core_clk) disable iff (rst)
      req.wr && req.addr == 8'h2a |=> col_cfg[7:4] == $past(req.wdata[7:4]))
      else $error("colour write lost");
   cov_ctl_low: cover property (@(posedge core_clk) ctl_low_start ##1
      scl_drive_low);
   cov_setup: cover property (@(posedge core_clk) tgt_setup_start ##[1:20]
      scl_release);
   cov_fc_load: cover property (@(posedge core_clk) fc_load &&
      !s_q.dp.block_remote_load);
endmodule

// File: verif/ddreg_remote_model.sv
`timescale 1ns/1ps
module ddreg_remote_model (
   input  wire logic core_clk,
   output logic       fc_load,
   output logic [7:0] fc_data,
   output logic       link_up_pin,
   output logic       video_active_pin
);
   initial begin
      fc_load = 1'b0;
      fc_data = 8'h00;
      link_up_pin = 1'b0;
      video_active_pin = 1'b0;
   end
   // Released data flips so a stale byte cannot pass as a load
   task automatic send(input logic [7:0] v);
      @(posedge core_clk);
      fc_load <= 1'b1;
      fc_data <= v;
      @(posedge core_clk);
      fc_load <= 1'b0;
      fc_data <= ~v;
   endtask
   task automatic set_link(input logic up, input logic vid);
      @(posedge core_clk);
      link_up_pin <= up;
      video_active_pin <= vid;
   endtask
endmodule

// File: verif/ddreg_top_tb.sv
`timescale 1ns/1ps
module ddreg_top_tb;
   import ddreg_pkg::*;
   logic       core_clk, rst, ctl_low_start, tgt_setup_start;
   logic       fc_load, link_up_pin, video_active_pin;
   logic       rvalid, scl_drive_low, scl_release, lock_out;
   logic [7:0] fc_data, rdata, v;
   ddreg_req_t req;
   ddreg_dp_t  dp_cfg;
   ddreg_tim_t tim_cfg;
   ddreg_col_t col_cfg;
   int         num_errors, samples_checked;
   ddreg_top u_ddreg_top (.core_clk(core_clk), .rst(rst), .req(req),
      .fc_load(fc_load), .fc_data(fc_data), .ctl_low_start(ctl_low_start),
      .tgt_setup_start(tgt_setup_start), .link_up_pin(link_up_pin),
      .video_active_pin(video_active_pin), .rdata(rdata), .rvalid(rvalid),
      .scl_drive_low(scl_drive_low), .scl_release(scl_release),
      .lock_out(lock_out), .dp_cfg(dp_cfg), .tim_cfg(tim_cfg),
      .col_cfg(col_cfg));
   ddreg_remote_model u_ddreg_remote_model (.core_clk(core_clk),
      .fc_load(fc_load), .fc_data(fc_data), .link_up_pin(link_up_pin),
      .video_active_pin(video_active_pin));
   task automatic results;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] s, e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic tmo(input int c, lim);
      if (c >= lim) begin
         num_errors++;
         results();
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge core_clk);
      req <= '{w, !w, a, d};
      @(posedge core_clk);
      req <= '0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, e);
      acc(1'b0, a, 8'h00);
      chk("rvalid", {7'h0, rvalid}, 8'h01);
      chk("rdata", rdata, e);
   endtask
   // Zero count is taken as one step
   task automatic phase(input logic ctl, input logic [7:0] n);
      int c;
      c = 0;
      acc(1'b1, 8'h27, n);
      @(posedge core_clk);
      ctl_low_start <= ctl;
      tgt_setup_start <= !ctl;
      @(posedge core_clk);
      ctl_low_start <= 1'b0;
      tgt_setup_start <= 1'b0;
      #1;
      while (scl_drive_low === 1'b1 && c < 2000) begin
         c++;
         @(posedge core_clk);
         #1;
      end
      tmo(c, 2000);
      chk("low_cycles", 8'(c), (n == 0) ? 8'h05 : 8'(n * 5));
      chk("release", {7'h0, scl_release}, 8'h01);
   endtask
   task automatic wait_lock(input logic x);
      int c;
      c = 0;
      while (lock_out !== x && c < 50) begin
         c++;
         @(posedge core_clk);
         #1;
      end
      tmo(c, 50);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      rst = 1'b1;
      req = '0;
      ctl_low_start = 1'b0;
      tgt_setup_start = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      chk("lock", {7'h0, lock_out}, 8'h00);
      rd_chk(8'h27, 8'h84);
      chk("slack", {7'h0, 32'(rdata) * 1000 / 26 >= 5000}, 8'h01);
      rd_chk(8'h28, 8'h20);
      rd_chk(8'h29, 8'h00);
      rd_chk(8'h2a, 8'h00);
      acc(1'b1, 8'h2b, 8'hff);
      rd_chk(8'h2b, 8'h00);
      acc(1'b1, 8'h28, 8'hff);
      rd_chk(8'h28, 8'hbf);
      for (int i = 0; i < 2; i++) begin
         v = i[0] ? 8'h5a : 8'ha5;
         acc(1'b1, 8'h29, v);
         chk("tim", tim_cfg, v);
         chk("stage_a", {7'h0, tim_cfg.dither_stage_a_on}, {7'h0, v[2]});
      end
      for (int p = 0; p < 4; p++) begin
         acc(1'b1, 8'h2a, {p[1:0], 2'b01, 4'hf});
         chk("page", {6'h0, col_cfg.page}, {6'h0, p[1:0]});
         rd_chk(8'h2a, {p[1:0], 2'b01, 4'h0});
      end
      acc(1'b1, 8'h28, 8'h00);
      u_ddreg_remote_model.send(8'h5b);
      #1;
      chk("dp_load", dp_cfg, 8'h1b);
      acc(1'b1, 8'h28, 8'h80);
      u_ddreg_remote_model.send(8'h1f);
      #1;
      chk("dp_kept", dp_cfg, 8'h80);
      acc(1'b1, 8'h28, 8'h00);
      phase(1'b1, 8'h03);
      phase(1'b0, 8'h02);
      phase(1'b1, 8'h00);
      u_ddreg_remote_model.set_link(1'b1, 1'b1);
      wait_lock(1'b1);
      chk("video_off", {7'h0, dp_cfg.video_off}, 8'h00);
      u_ddreg_remote_model.set_link(1'b1, 1'b0);
      wait_lock(1'b0);
      chk("video_off", {7'h0, dp_cfg.video_off}, 8'h01);
      results();
   end
endmodule
